// [hw/bdts_pkg.sv]
// Shared constants and types for the board decode, tick and step logic.
package bdts_pkg;

  // Memory window bases selected by the base jumpers.
  localparam logic [1:0]  BASE_SEL_ZERO   = 2'h0;
  localparam logic [1:0]  BASE_SEL_HIGH   = 2'h1;
  localparam logic [1:0]  BASE_SEL_TOP    = 2'h2;
  localparam logic [15:0] WIN_BASE_ZERO   = 16'h0000;
  localparam logic [15:0] WIN_BASE_HIGH   = 16'h8000;
  localparam logic [15:0] WIN_BASE_TOP    = 16'hE000;
  localparam int          WIN_TOP_BIT     = 15;
  localparam int          WIN_LOW_BIT     = 12;
  localparam int          OFF_W           = 12;

  // Kilobyte slots inside the window.
  localparam int          KB_HI_BIT       = 11;
  localparam int          KB_LO_BIT       = 10;
  localparam logic [1:0]  KB_ROM0         = 2'h0;
  localparam logic [1:0]  KB_ROM1         = 2'h1;
  localparam logic [1:0]  KB_ROM2         = 2'h2;
  localparam logic [1:0]  KB_RAM          = 2'h3;
  localparam int          ROM_SOCKETS     = 3;
  localparam int          RAM_AW          = 9;
  localparam int          RAM_WORDS       = 512;

  // Port page: the high nibble of the port address follows the window base.
  localparam int          PORT_HI_BIT     = 7;
  localparam int          PORT_LO_BIT     = 4;
  localparam int          PORT_GRP_HI     = 3;
  localparam int          PORT_GRP_LO     = 2;
  localparam logic [1:0]  GRP_SERIAL      = 2'h0;
  localparam logic [1:0]  GRP_BAUD        = 2'h1;
  localparam logic [1:0]  GRP_TICK_CLR    = 2'h2;
  localparam logic [1:0]  GRP_STEP_ARM    = 2'h3;

  // Register offsets inside the port page.
  localparam logic [3:0]  REG_SERIAL_STATUS_AND_COMMAND = 4'h0;
  localparam logic [3:0]  REG_SERIAL_DATA_PORT          = 4'h1;
  localparam logic [3:0]  REG_BAUD_SELECT_LATCH         = 4'h4;
  localparam logic [3:0]  REG_TICK_CLEAR_PORT           = 4'h8;
  localparam logic [3:0]  REG_STEP_ARM_PORT             = 4'hC;

  // Vectored interrupts: number k restarts at (7 - k) * 8.
  localparam int          NUM_VEC         = 8;
  localparam int          VEC_SPACING     = 8;
  localparam int          VEC_AREA        = 64;
  localparam int          STEP_INT_NUM    = 0;
  localparam int          TICK_INT_NUM    = 1;
  localparam logic [7:0]  STEP_VEC_ADDR   = 8'h38;
  localparam logic [7:0]  TICK_VEC_ADDR   = 8'h30;
  localparam logic [2:0]  LAST_RESTART    = 3'h7;

  // Single step counts this many instruction fetches before trapping.
  localparam logic [1:0]  STEP_FETCHES    = 2'h2;

  // Power-on reset time and its cycle count at the 20 MHz clock.
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          POR_TIME_US     = 500000;
  localparam int          POR_CYCLES      = POR_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int          POR_CNT_W       = 24;

  typedef enum logic [0:0] {STEP_IDLE, STEP_ARMED} bdts_step_state_t;

  // One processor bus cycle as seen by the board.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        mem_rd;
    logic        mem_wr;
    logic        io_rd;
    logic        io_wr;
    logic        fetch;
    logic        int_ack;
  } bdts_cyc_t;

  // Chip selects for the onboard devices.
  typedef struct packed {
    logic [2:0] rom;
    logic       ram;
    logic       serial;
    logic       baud;
  } bdts_sel_t;

endpackage

// [hw/bdts_ram.sv]
// Onboard 512-byte read/write memory with registered read data.
`timescale 1ns/1ns
module bdts_ram #(
  parameter int AW = bdts_pkg::RAM_AW,
  parameter int WORDS = bdts_pkg::RAM_WORDS
) (
  input  wire logic          mclk_i,
  input  wire logic          srst_i,
  input  wire logic          we_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  output logic      [7:0]    rdata_o,
  output logic               rvalid_o
);

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
  } bdts_ram_st_t;

  logic [7:0]   mem_q [WORDS];
  bdts_ram_st_t st_q;
  bdts_ram_st_t st_d;

  always_comb
  begin
    st_d        = st_q;
    st_d.rvalid = re_i;
    if (re_i)
    begin
      st_d.rdata = mem_q[addr_i];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Contents are not cleared by reset, as with the real static parts.
  always_ff @(posedge mclk_i)
  begin
    if (we_i)
    begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  assign rdata_o  = st_q.rdata;
  assign rvalid_o = st_q.rvalid;

endmodule

// [hw/bdts_step.sv]
// Single-step trap generator: arm, count fetches, raise the trap.
`timescale 1ns/1ns
module bdts_step (
  input  wire logic mclk_i,
  input  wire logic srst_i,
  input  wire logic arm_i,
  input  wire logic fetch_i,
  input  wire logic ack_i,
  output logic      mask_o,
  output logic      trap_o
);

  typedef struct packed {
    bdts_pkg::bdts_step_state_t state;
    logic [1:0]                 cnt;
    logic                       trap;
  } bdts_step_st_t;

  bdts_step_st_t st_q;
  bdts_step_st_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (ack_i)
    begin
      st_d.trap = 1'b0;
    end
    unique case (st_q.state)
      bdts_pkg::STEP_IDLE:
      begin
        st_d.cnt = 2'h0;
      end
      bdts_pkg::STEP_ARMED:
      begin
        if (fetch_i)
        begin
          st_d.cnt = st_q.cnt + 2'h1;
          if (st_q.cnt + 2'h1 == bdts_pkg::STEP_FETCHES)
          begin
            st_d.trap  = 1'b1;
            st_d.state = bdts_pkg::STEP_IDLE;
            st_d.cnt   = 2'h0;
          end
        end
      end
    endcase
    if (arm_i)
    begin
      st_d.state = bdts_pkg::STEP_ARMED;
      st_d.cnt   = 2'h0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign mask_o = (st_q.state == bdts_pkg::STEP_ARMED);
  assign trap_o = st_q.trap;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  a_step_arms: assert property (arm_i |=> mask_o)
    else $error("step logic not armed after port write");
  a_step_idle: assert property ($rose(trap_o) |-> !mask_o)
    else $error("step logic still masking after trap");
  a_step_count: assert property (arm_i ##1 (!arm_i && !fetch_i) [*1] ##1
                                 (fetch_i && !arm_i) [*2] |=> trap_o)
    else $error("trap not raised after two fetches");

endmodule

// [hw/bdts_top.sv]
// Board support logic: window decode, port decode, tick latch, step trap, power-on reset.
//
// Function
// - Onboard memory is one 4K window, jumper based.
// - Default jumpers put window base at zero.
// - Port page follows window, same jumpers.
// - Lowest 3K of window: three ROM sockets.
// - Top 1K of window selects 512-byte RAM.
// - RAM ignores address bit 9, aliasing twice.
// - Mains rising edge raises tick request.
// - Tick request stays latched until cleared.
// - Write to tick-clear port clears latch.
// - Tick routes by jumper to interrupt 1.
// - Write to step port arms step logic.
// - Armed step logic masks other interrupts.
// - After two fetches trap to 38H.
// - After trap, step idles and unmasks.
// - Eight restart targets, 8 apart, first 64.
// - Power-on reset held about half second.
`timescale 1ns/1ns
module bdts_top #(
  parameter int unsigned POR_CYCLES = bdts_pkg::POR_CYCLES
) (
  input  wire logic                mclk_i,
  input  wire logic                srst_i,
  input  wire bdts_pkg::bdts_cyc_t cyc_i,
  input  wire logic [1:0]          base_sel_i,
  input  wire logic                tick_route_i,
  input  wire logic                line_freq_i,
  input  wire logic [7:0]          ext_irq_i,
  output bdts_pkg::bdts_sel_t      sel_o,
  output logic      [7:0]          rdata_o,
  output logic                     rdata_oe_o,
  output logic                     int_req_o,
  output logic      [7:0]          int_vec_o,
  output logic                     cpu_reset_o
);

  typedef struct packed {
    logic                              line_s1;
    logic                              line_s2;
    logic                              line_s3;
    logic                              tick;
    logic [bdts_pkg::POR_CNT_W-1:0]    por_cnt;
    logic                              por_done;
    logic                              irq;
    logic [7:0]                        vec;
  } bdts_top_st_t;

  localparam logic [bdts_pkg::POR_CNT_W-1:0] POR_LAST =
    bdts_pkg::POR_CNT_W'(POR_CYCLES - 1);

  bdts_top_st_t st_q;
  bdts_top_st_t st_d;

  logic [15:0]                   win_base;
  logic                          in_win;
  logic [bdts_pkg::OFF_W-1:0]    win_off;
  logic [1:0]                    kb_slot;
  logic                          port_hit;
  logic [1:0]                    port_grp;
  logic                          tick_clr;
  logic                          step_arm;
  logic                          line_rise;
  logic                          ram_we;
  logic                          ram_re;
  logic                          step_mask;
  logic                          step_trap;
  logic                          step_ack;
  logic [bdts_pkg::NUM_VEC-1:0]  src;
  logic                          any_src;
  logic [2:0]                    win_num;

  // Window base from the jumpers; an unused code falls back to the default.
  always_comb
  begin
    unique case (base_sel_i)
      bdts_pkg::BASE_SEL_HIGH: win_base = bdts_pkg::WIN_BASE_HIGH;
      bdts_pkg::BASE_SEL_TOP:  win_base = bdts_pkg::WIN_BASE_TOP;
      default:                 win_base = bdts_pkg::WIN_BASE_ZERO;
    endcase
  end

  assign in_win  = cyc_i.addr[bdts_pkg::WIN_TOP_BIT:bdts_pkg::WIN_LOW_BIT] ==
                   win_base[bdts_pkg::WIN_TOP_BIT:bdts_pkg::WIN_LOW_BIT];
  assign win_off = cyc_i.addr[bdts_pkg::OFF_W-1:0];
  assign kb_slot = win_off[bdts_pkg::KB_HI_BIT:bdts_pkg::KB_LO_BIT];

  // The port page nibble is the window base nibble one byte lower down.
  assign port_hit = cyc_i.addr[bdts_pkg::PORT_HI_BIT:bdts_pkg::PORT_LO_BIT] ==
                    win_base[bdts_pkg::WIN_TOP_BIT:bdts_pkg::WIN_LOW_BIT];
  assign port_grp = cyc_i.addr[bdts_pkg::PORT_GRP_HI:bdts_pkg::PORT_GRP_LO];

  // Chip selects are pure decode so the sockets see them in the same cycle.
  always_comb
  begin
    sel_o        = '0;
    sel_o.rom[0] = in_win && (kb_slot == bdts_pkg::KB_ROM0);
    sel_o.rom[1] = in_win && (kb_slot == bdts_pkg::KB_ROM1);
    sel_o.rom[2] = in_win && (kb_slot == bdts_pkg::KB_ROM2);
    sel_o.ram    = in_win && (kb_slot == bdts_pkg::KB_RAM);
    sel_o.serial = port_hit && (port_grp == bdts_pkg::GRP_SERIAL)
                   && (cyc_i.io_rd || cyc_i.io_wr);
    sel_o.baud   = port_hit && (port_grp == bdts_pkg::GRP_BAUD)
                   && cyc_i.io_wr;
  end

  // Reads of the upper port groups are unused and get no answer.
  assign tick_clr = port_hit && (port_grp == bdts_pkg::GRP_TICK_CLR) && cyc_i.io_wr;
  assign step_arm = port_hit && (port_grp == bdts_pkg::GRP_STEP_ARM) && cyc_i.io_wr;

  assign ram_we = sel_o.ram && cyc_i.mem_wr;
  assign ram_re = sel_o.ram && cyc_i.mem_rd;

  // Bit 9 is dropped, so both halves of the top kilobyte hit the same cells.
  bdts_ram u_ram (
    .mclk_i   (mclk_i),
    .srst_i   (srst_i),
    .we_i     (ram_we),
    .re_i     (ram_re),
    .addr_i   (win_off[bdts_pkg::RAM_AW-1:0]),
    .wdata_i  (cyc_i.wdata),
    .rdata_o  (rdata_o),
    .rvalid_o (rdata_oe_o)
  );

  assign step_ack = cyc_i.int_ack && (int_vec_o == bdts_pkg::STEP_VEC_ADDR);

  bdts_step u_step (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .arm_i   (step_arm),
    .fetch_i (cyc_i.fetch),
    .ack_i   (step_ack),
    .mask_o  (step_mask),
    .trap_o  (step_trap)
  );

  // Mains edge from the second synchroniser stage against a third stage.
  assign line_rise = st_q.line_s2 && !st_q.line_s3;

  // Interrupt sources by number; armed step logic masks all the others.
  always_comb
  begin
    src = step_mask ? '0 : ext_irq_i;
    if (!step_mask && tick_route_i && st_q.tick)
    begin
      src[bdts_pkg::TICK_INT_NUM] = 1'b1;
    end
    if (step_trap)
    begin
      src[bdts_pkg::STEP_INT_NUM] = 1'b1;
    end
  end

  // Lowest number wins; number k restarts at (7 - k) times eight.
  always_comb
  begin
    any_src = 1'b0;
    win_num = 3'h0;
    for (int k = bdts_pkg::NUM_VEC - 1; k >= 0; k--)
    begin
      if (src[k])
      begin
        any_src = 1'b1;
        win_num = 3'(k);
      end
    end
  end

  always_comb
  begin
    st_d         = st_q;
    st_d.line_s1 = line_freq_i;
    st_d.line_s2 = st_q.line_s1;
    st_d.line_s3 = st_q.line_s2;
    // A clear in the same cycle as an edge loses, so no tick is dropped.
    if (tick_clr)
    begin
      st_d.tick = 1'b0;
    end
    if (line_rise)
    begin
      st_d.tick = 1'b1;
    end
    if (!st_q.por_done)
    begin
      st_d.por_cnt = st_q.por_cnt + 1'b1;
      if (st_q.por_cnt == POR_LAST)
      begin
        st_d.por_done = 1'b1;
      end
    end
    // The request is only a level; acceptance waits on the processor's enable.
    st_d.irq = any_src && st_q.por_done;
    st_d.vec = {2'h0, bdts_pkg::LAST_RESTART - win_num, 3'h0};
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Held in reset, the processor clears its counter and disables interrupts.
  assign cpu_reset_o = !st_q.por_done;
  assign int_req_o   = st_q.irq;
  assign int_vec_o   = st_q.vec;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  a_tick_set: assert property (line_rise |=> st_q.tick)
    else $error("tick edge not latched");
  a_tick_hold: assert property (st_q.tick && !tick_clr |=> st_q.tick)
    else $error("tick latch dropped without clear");
  a_tick_clear: assert property (tick_clr && !line_rise |=> !st_q.tick)
    else $error("tick latch not cleared by port write");
  a_tick_vector: assert property (st_q.tick && tick_route_i && !step_mask && !step_trap
                                  && ext_irq_i[0] == 1'b0 && st_q.por_done
                                  |=> int_req_o && int_vec_o == bdts_pkg::TICK_VEC_ADDR)
    else $error("tick not vectored to 30H");
  a_step_only: assert property (step_mask |=> !int_req_o)
    else $error("interrupt leaked while step armed");
  a_step_vector: assert property (step_trap && st_q.por_done
                                  |=> int_req_o && int_vec_o == bdts_pkg::STEP_VEC_ADDR)
    else $error("step trap not vectored to 38H");
  a_vec_grid: assert property (int_req_o |-> int_vec_o[2:0] == 3'h0
                               && int_vec_o < 8'(bdts_pkg::VEC_AREA))
    else $error("vector off the restart grid");
  a_rom_split: assert property (in_win && kb_slot != bdts_pkg::KB_RAM
                                |-> $onehot(sel_o.rom) && !sel_o.ram)
    else $error("rom socket decode wrong");
  a_ram_top: assert property (sel_o.ram |-> in_win && win_off[11:10] == 2'h3)
    else $error("ram selected outside top kilobyte");
  a_ram_alias: assert property (ram_we ##1 (ram_re && !ram_we
                                && win_off[8:0] == $past(win_off[8:0]))
                                |=> rdata_o == $past(cyc_i.wdata, 2))
    else $error("ram alias read mismatch");
  a_win_default: assert property (base_sel_i == bdts_pkg::BASE_SEL_ZERO
                                  |-> in_win == (cyc_i.addr[15:12] == 4'h0))
    else $error("default window not at zero");
  a_port_follow: assert property (tick_clr |-> cyc_i.addr[7:4] == win_base[15:12])
    else $error("port page not tied to window base");
  a_por_hold: assert property (!st_q.por_done |-> cpu_reset_o && !int_req_o)
    else $error("reset released early");

  c_tick_irq: cover property (line_rise ##[1:3] int_req_o);
  c_step_trap: cover property (step_arm ##[1:40] step_trap);
  c_ram_read: cover property (ram_we ##[1:20] rdata_oe_o);
  c_por_release: cover property ($fell(cpu_reset_o));

endmodule

// [testbench/bdts_cpu_model.sv]
// Processor core model that issues bus cycles and accepts vectored interrupts.
`timescale 1ns/1ns
module bdts_cpu_model (
  input  wire logic           mclk_i,
  input  wire logic           int_req_i,
  input  wire logic [7:0]     int_vec_i,
  output bdts_pkg::bdts_cyc_t cyc_o
);
  logic ie_q;

  initial
  begin
    cyc_o = '0;
    ie_q  = 1'b0;
  end

  // Kinds: 0 idle, 1 memory read, 2 memory write, 3 port read, 4 port write, 5 fetch, 6 ack.
  task automatic put(input int kind, input logic [15:0] addr, input logic [7:0] data);
    @(negedge mclk_i);
    cyc_o.addr    = addr;
    // The data bus is not held outside writes, so it toggles rather than keeping old data.
    cyc_o.wdata   = (kind == 2 || kind == 4) ? data : ~cyc_o.wdata;
    cyc_o.mem_rd  = kind == 1;
    cyc_o.mem_wr  = kind == 2;
    cyc_o.io_rd   = kind == 3;
    cyc_o.io_wr   = kind == 4;
    cyc_o.fetch   = kind == 5;
    cyc_o.int_ack = kind == 6;
  endtask

  task automatic idle(input int cycles);
    repeat (cycles) put(0, cyc_o.addr, 8'h00);
  endtask

  // Enables interrupts, then takes the first request seen within the bound.
  task automatic accept(input int max, output logic [7:0] vec, output bit ok);
    ie_q = 1'b1;
    ok   = 1'b0;
    vec  = 8'h00;
    for (int i = 0; i < max && !ok; i++)
    begin
      idle(1);
      if (ie_q && int_req_i === 1'b1)
      begin
        vec = int_vec_i;
        put(6, cyc_o.addr, 8'h00);
        ie_q = 1'b0;
        ok   = 1'b1;
      end
    end
    idle(1);
  endtask

  // Tick service clears the latch first; enabling earlier would re-interrupt at once.
  task automatic tick_isr(input logic [7:0] port);
    put(4, {8'h00, port}, 8'h00);
    ie_q = 1'b1;
  endtask
endmodule

// [testbench/test_board_decode_tick_and_step.sv]
// Self-checking bench for the board decode, tick and step logic.
`timescale 1ns/1ns
module test_board_decode_tick_and_step;
  localparam int POR = 20;
  logic                mclk_i     = 1'b0;
  logic                srst_i     = 1'b1;
  logic [1:0]          base_sel   = 2'h0;
  logic                tick_route = 1'b0;
  logic                line_freq  = 1'b0;
  logic [7:0]          ext_irq    = 8'hFF;
  bdts_pkg::bdts_cyc_t cyc;
  bdts_pkg::bdts_sel_t sel;
  logic [7:0]          rdata;
  logic [7:0]          int_vec;
  logic                rdata_oe;
  logic                int_req;
  logic                cpu_reset;
  int                  fail_count = 0;
  int                  n_tests    = 0;
  int                  i;
  int                  k;
  logic [7:0]          mem [512];
  logic [15:0]         a;
  logic [8:0]          off;
  logic [7:0]          d;
  logic [7:0]          v;
  logic [3:0]          n;
  bit                  ok;

  always #25 mclk_i = ~mclk_i;

  bdts_top #(
    .POR_CYCLES(POR)
  ) i_bdts_top (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .cyc_i       (cyc),
    .base_sel_i  (base_sel),
    .tick_route_i(tick_route),
    .line_freq_i (line_freq),
    .ext_irq_i   (ext_irq),
    .sel_o       (sel),
    .rdata_o     (rdata),
    .rdata_oe_o  (rdata_oe),
    .int_req_o   (int_req),
    .int_vec_o   (int_vec),
    .cpu_reset_o (cpu_reset)
  );

  bdts_cpu_model cpu (
    .mclk_i   (mclk_i),
    .int_req_i(int_req),
    .int_vec_i(int_vec),
    .cyc_o    (cyc)
  );

  task automatic report(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    report({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    report({8'h00, got}, {8'h00, exp});
  endtask

  task automatic chk_sel(input bdts_pkg::bdts_sel_t got, input bdts_pkg::bdts_sel_t exp);
    report({10'h000, got}, {10'h000, exp});
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [3:0] nib(input logic [1:0] b);
    return (b == 2'h1) ? 4'h8 : (b == 2'h2) ? 4'hE : 4'h0;
  endfunction

  function automatic bdts_pkg::bdts_sel_t exp_sel(input logic [15:0] adr);
    bdts_pkg::bdts_sel_t s;
    s = '0;
    if (adr[15:12] == nib(base_sel))
    begin
      if (adr[11:10] == 2'h3)
        s.ram = 1'b1;
      else
        s.rom[adr[11:10]] = 1'b1;
    end
    return s;
  endfunction

  function automatic logic [7:0] exp_io(input int kind, input logic [7:0] p);
    exp_io = 8'h00;
    if (p[7:4] == nib(base_sel))
      exp_io = {6'h00, p[3:2] == 2'h0, kind == 4 && p[3:2] == 2'h1};
  endfunction

  initial
  begin
    #500000;
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(70));
    repeat (4) @(negedge mclk_i);
    srst_i = 1'b0;
    repeat (POR - 2) @(negedge mclk_i);
    chk1(cpu_reset, 1'b1);
    chk1(int_req, 1'b0);
    for (i = 0; i < 8 && cpu_reset !== 1'b0; i++) @(negedge mclk_i);
    chk1(cpu_reset, 1'b0);
    if (cpu_reset !== 1'b0)
      tally_and_finish();
    // Port writes stay out of groups 2 and 3 here, so no latch or arm leaks into later steps.
    for (k = 0; k < 4; k++)
    begin
      base_sel = k[1:0];
      for (i = 0; i < 24; i++)
      begin
        a = 16'($urandom);
        if (i[0])
          a[15:12] = nib(base_sel);
        cpu.put(1 + i % 2, a, a[7:0]);
        #1;
        chk_sel(sel, exp_sel(a));
        a = 16'($urandom);
        if (i[1])
          a[7:4] = nib(base_sel);
        if (i % 2 == 1)
          a[3] = 1'b0;
        cpu.put(3 + i % 2, a, 8'h00);
        #1;
        chk8({6'h00, sel.serial, sel.baud}, exp_io(3 + i % 2, a[7:0]));
      end
    end
    base_sel = 2'h2;
    n = nib(base_sel);
    for (i = 0; i < 32; i++)
    begin
      off = 9'($urandom);
      d = 8'($urandom);
      mem[off] = d;
      cpu.put(2, {n, 2'h3, i[0], off}, d);
      cpu.put(2, {n ^ 4'h1, 2'h3, i[0], off}, ~d);
      cpu.put(1, {n, 2'h3, ~i[0], off}, 8'h00);
      cpu.idle(1);
      #1;
      chk1(rdata_oe, 1'b1);
      chk8(rdata, mem[off]);
    end
    // Back-to-back write then aliased read must return the new byte at once.
    off = 9'($urandom);
    d = 8'($urandom);
    mem[off] = d;
    cpu.put(2, {n, 2'h3, 1'b0, off}, d);
    cpu.put(1, {n, 2'h3, 1'b1, off}, 8'h00);
    cpu.idle(1);
    #1;
    chk8(rdata, mem[off]);
    cpu.idle(1);
    #1;
    chk1(rdata_oe, 1'b0);
    base_sel = 2'h1;
    n = nib(base_sel);
    ext_irq = 8'h00;
    tick_route = 1'b1;
    @(negedge mclk_i);
    line_freq = 1'b1;
    cpu.accept(10, v, ok);
    chk1(ok, 1'b1);
    if (!ok)
      tally_and_finish();
    chk8(v, 8'h30);
    line_freq = 1'b0;
    cpu.idle(6);
    #1;
    chk1(int_req, 1'b1);
    cpu.put(3, {8'h00, n, 4'h8}, 8'h00);
    cpu.idle(3);
    #1;
    chk1(int_req, 1'b1);
    cpu.tick_isr({n, 2'h2, 2'($urandom)});
    cpu.idle(2);
    #1;
    chk1(int_req, 1'b0);
    @(negedge mclk_i);
    tick_route = 1'b0;
    line_freq = 1'b1;
    cpu.idle(8);
    #1;
    chk1(int_req, 1'b0);
    @(negedge mclk_i);
    tick_route = 1'b1;
    line_freq = 1'b0;
    cpu.idle(3);
    #1;
    chk8(int_req ? int_vec : 8'hFF, 8'h30);
    cpu.tick_isr({n, 2'h2, 2'($urandom)});
    @(negedge mclk_i);
    ext_irq = 8'h08;
    cpu.idle(3);
    #1;
    chk8(int_req ? int_vec : 8'hFF, 8'h20);
    cpu.put(4, {8'h00, n, 2'h3, 2'($urandom)}, 8'h00);
    cpu.idle(2);
    #1;
    chk1(int_req, 1'b0);
    cpu.put(5, 16'h0000, 8'h00);
    cpu.idle(3);
    #1;
    chk1(int_req, 1'b0);
    cpu.put(5, 16'h0000, 8'h00);
    cpu.accept(4, v, ok);
    chk1(ok, 1'b1);
    if (!ok)
      tally_and_finish();
    chk8(v, 8'h38);
    cpu.idle(3);
    #1;
    chk8(int_req ? int_vec : 8'hFF, 8'h20);
    for (k = 0; k < 8; k++)
    begin
      @(negedge mclk_i);
      ext_irq = 8'(($urandom << k) | (1 << k));
      cpu.idle(3);
      #1;
      chk8(int_req ? int_vec : 8'hFF, 8'((7 - k) * 8));
    end
    // A second reset in mid-run must restart the power-on hold and hide requests.
    @(negedge mclk_i);
    srst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    srst_i = 1'b0;
    @(negedge mclk_i);
    chk1(cpu_reset, 1'b1);
    chk1(int_req, 1'b0);
    chk1(rdata_oe, 1'b0);
    for (i = 0; i < POR + 4 && cpu_reset !== 1'b0; i++) @(negedge mclk_i);
    chk1(cpu_reset, 1'b0);
    cpu.idle(3);
    #1;
    chk8(int_req ? int_vec : 8'hFF, 8'h00);
    tally_and_finish();
  end
endmodule
